// file: design/msw_top.sv
// multi-rail supervisor: reset hold, watchdog, margin and register slave
//
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
module msw_top #(
  parameter int unsigned N        = msw_pkg::RAILS,     // monitored rails
  parameter int unsigned HOLD_CYC = msw_pkg::HOLD_CYC,  // reset hold count
  parameter int unsigned WD_CYC   = msw_pkg::WD_CYC,    // watchdog count
  parameter int unsigned MD_CYC   = msw_pkg::MD_CYC     // margin release count
) (
  input  wire logic                      clk_i,                    // 100 MHz clock
  input  wire logic                      rstn_i,                   // async reset, active low
  input  wire logic [N-1:0]              rail_uv5_i,               // undervoltage, 5% set
  input  wire logic [N-1:0]              rail_uv10_i,              // undervoltage, 10% set
  input  wire logic                      threshold_tolerance_sel_i, // 0: 5%, 1: 10%
  input  wire logic                      manual_reset_n_i,         // manual reset, active low
  input  wire logic                      margin_n_i,               // margin test, active low
  input  wire logic                      watchdog_kick_in_i,       // kick from processor
  input  wire logic                      watchdog_kick_driven_i,   // high while kick is driven
  output logic [N-1:0]                   rail_status_n_o,          // per-rail status, low = bad
  output logic                           sys_reset_n_o,            // system reset, active low
  output logic                           watchdog_fault_out_n_o,   // watchdog fault, active low
  input  wire logic [msw_pkg::ADDR_W-1:0] avs_address_i,           // byte address
  input  wire logic                      avs_read_i,               // read request
  input  wire logic                      avs_write_i,              // write request
  input  wire logic [31:0]               avs_writedata_i,          // write data
  input  wire logic [3:0]                avs_byteenable_i,         // byte lanes
  output logic [31:0]                    avs_readdata_o,           // read data
  output logic                           avs_waitrequest_o         // stall
);
  typedef struct packed {
    logic [31:0]                hold_cnt;
    logic                       rst_active;
    logic [31:0]                wd_cnt;
    logic                       wdo_flag;
    logic                       kick_prev;
    logic [31:0]                md_cnt;
    logic                       md_busy;
    logic [N-1:0]               rail_n;
    logic                       rst_n;
    logic                       wdo_n;
    logic                       to_reset;
    logic [msw_pkg::EV_W-1:0]   evt;
    logic                       ack;
    logic [31:0]                rdata;
  } msw_state_type;

  localparam msw_state_type RST_STATE = '{
    rst_active: 1'b1,
    rail_n:     {N{1'b1}},
    wdo_n:      1'b1,
    to_reset:   msw_pkg::CTRL_RESET_VAL,
    default:    '0
  };

  msw_state_type s_ff;
  msw_state_type nxt_s;
  logic          any_uv;
  logic          kick_edge;
  logic          wd_exp;
  logic          out_hold;
  logic          req;
  logic [31:0]   status_word;
  logic [msw_pkg::EV_W-1:0] ev_set;
  logic [msw_pkg::EV_W-1:0] ev_clr;

  msw_sync_if #(.N(N)) sif ();

  // raw pins into the synchroniser
  assign sif.uv5_raw      = rail_uv5_i;
  assign sif.uv10_raw     = rail_uv10_i;
  assign sif.tol_raw      = threshold_tolerance_sel_i;
  assign sif.mr_raw_n     = manual_reset_n_i;
  assign sif.margin_raw_n = margin_n_i;
  assign sif.kick_raw     = watchdog_kick_in_i;
  assign sif.kick_en_raw  = watchdog_kick_driven_i;

  msw_sync #(.N(N)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .sif    (sif)
  );

  // address decode used by read and write paths
  function automatic logic is_ofs(input logic [msw_pkg::ADDR_W-1:0] a, input logic [3:0] ofs);
    is_ofs = (a[3:2] == ofs[3:2]);
  endfunction : is_ofs

  // status word assembled from live state
  always_comb begin
    status_word = '0;
    status_word[msw_pkg::ST_UV_LSB +: N]    = sif.uv;
    status_word[msw_pkg::ST_RST_ACTIVE]     = s_ff.rst_active;
    status_word[msw_pkg::ST_WDO_FLAG]       = s_ff.wdo_flag;
    status_word[msw_pkg::ST_MARGIN_HOLD]    = out_hold;
    status_word[msw_pkg::ST_KICK_EN]        = sif.kick_en;
  end

  assign req      = avs_read_i | avs_write_i;
  assign any_uv   = |sif.uv;
  assign out_hold = ~sif.margin_n | s_ff.md_busy;

  // supervisor and bus next-state logic
  always_comb begin
    nxt_s     = s_ff;
    wd_exp    = 1'b0;
    ev_set    = '0;
    ev_clr    = '0;
    kick_edge = sif.kick_en & (sif.kick ^ s_ff.kick_prev);
    nxt_s.kick_prev = sif.kick;

    // reset hold timing
    if (any_uv | ~sif.mr_n) begin
      nxt_s.rst_active = 1'b1;
      nxt_s.hold_cnt   = '0;
    end else if (s_ff.rst_active) begin
      if (s_ff.hold_cnt >= HOLD_CYC - 1) begin
        nxt_s.rst_active = 1'b0;
        nxt_s.hold_cnt   = '0;
        ev_set[msw_pkg::EV_RST_RELEASED] = 1'b1;
      end else begin
        nxt_s.hold_cnt = s_ff.hold_cnt + 32'h1;
      end
    end

    // watchdog runs only once the hold is over and kick is driven
    if (s_ff.rst_active | ~sif.kick_en | kick_edge) begin
      nxt_s.wd_cnt = '0;
    end else if (s_ff.wd_cnt >= WD_CYC - 1) begin
      wd_exp       = 1'b1;
      nxt_s.wd_cnt = '0;
    end else begin
      nxt_s.wd_cnt = s_ff.wd_cnt + 32'h1;
    end

    // expiry either restarts the reset hold or flags a fault
    if (wd_exp) begin
      ev_set[msw_pkg::EV_WD_EXPIRED] = 1'b1;
      if (s_ff.to_reset) begin
        nxt_s.rst_active = 1'b1;
        nxt_s.hold_cnt   = '0;
      end else begin
        nxt_s.wdo_flag = 1'b1;
      end
    end else if (kick_edge | ~sif.mr_n) begin
      nxt_s.wdo_flag = 1'b0;
    end

    // margin release delay
    if (~sif.margin_n) begin
      nxt_s.md_busy = 1'b1;
      nxt_s.md_cnt  = '0;
    end else if (s_ff.md_busy) begin
      if (s_ff.md_cnt >= MD_CYC - 1) begin
        nxt_s.md_busy = 1'b0;
        nxt_s.md_cnt  = '0;
      end else begin
        nxt_s.md_cnt = s_ff.md_cnt + 32'h1;
      end
    end

    // output stage, forced inactive during margin and its release delay
    if (out_hold) begin
      nxt_s.rail_n = {N{1'b1}};
      nxt_s.rst_n  = 1'b1;
      nxt_s.wdo_n  = 1'b1;
    end else begin
      nxt_s.rail_n = ~sif.uv;
      nxt_s.rst_n  = ~nxt_s.rst_active;
      nxt_s.wdo_n  = ~(any_uv | nxt_s.wdo_flag);
    end

    // bus slave: one wait cycle, then the access completes
    nxt_s.ack = req & ~s_ff.ack;
    if (avs_read_i & ~s_ff.ack) begin
      if (is_ofs(avs_address_i, msw_pkg::OFS_CTRL)) begin
        nxt_s.rdata = {31'h0, s_ff.to_reset};
      end else if (is_ofs(avs_address_i, msw_pkg::OFS_STATUS)) begin
        nxt_s.rdata = status_word;
      end else if (is_ofs(avs_address_i, msw_pkg::OFS_EVENT)) begin
        nxt_s.rdata = {{(32 - msw_pkg::EV_W){1'b0}}, s_ff.evt};
      end else begin
        nxt_s.rdata = 32'h0;
      end
    end
    if (avs_write_i & s_ff.ack & avs_byteenable_i[0]) begin
      if (is_ofs(avs_address_i, msw_pkg::OFS_CTRL)) begin
        nxt_s.to_reset = avs_writedata_i[msw_pkg::CTRL_TO_RESET];
      end else if (is_ofs(avs_address_i, msw_pkg::OFS_EVENT)) begin
        ev_clr = avs_writedata_i[msw_pkg::EV_W-1:0];
      end
    end
    // sticky events, a new event wins over a clear
    nxt_s.evt = (s_ff.evt & ~ev_clr) | ev_set;
  end

  // single state register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_ff <= RST_STATE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rail_status_n_o        = s_ff.rail_n;
  assign sys_reset_n_o          = s_ff.rst_n;
  assign watchdog_fault_out_n_o = s_ff.wdo_n;
  assign avs_readdata_o         = s_ff.rdata;
  assign avs_waitrequest_o      = req & ~s_ff.ack;
endmodule : msw_top

// file: design/msw_pkg.sv
// constants for the multi-rail supervisor with watchdog
//
// Overview of operation
// - each rail status output is low while its own rail is undervoltage
// - system reset goes low when any rail is low or manual reset asserted
// - reset stays asserted a full hold period after rails good and manual release
// - default reset hold period is at least 140 ms, adjustable by setting
// - missed kick for about 1.6 s asserts reset or the fault output, per the control register to_reset bit
// - watchdog is disabled while the kick input is not driven
// - tolerance select low picks 5% thresholds, high picks 10% thresholds
// - watchdog fault output is low while any rail is undervoltage
// - watchdog fault output releases at once when all rails return good
// - with rails good and to_reset clear, watchdog fault output goes low at each timer expiry
// - watchdog fault releases on a valid kick or manual reset low
// - watchdog counts only after the reset hold period has elapsed
// - margin low forces the watchdog fault output inactive, whatever else
// - watchdog keeps running during margin, a timeout is retained
// - margin active holds every supervisory output inactive high
// - retained timeout asserts its output a fixed delay after margin release
// - outputs do not change while margin is active
package msw_pkg;
  // clock and timing
  localparam int unsigned CLK_KHZ          = 100000;
  localparam int unsigned HOLD_TIME_MS     = 140;
  localparam int unsigned HOLD_CYC         = HOLD_TIME_MS * CLK_KHZ;
  localparam int unsigned WD_TIME_MS       = 1600;
  localparam int unsigned WD_CYC           = WD_TIME_MS * CLK_KHZ;
  localparam int unsigned MD_TIME_US       = 10;
  localparam int unsigned MD_CYC           = (MD_TIME_US * CLK_KHZ) / 1000;
  localparam int unsigned RAILS            = 8;
  localparam int unsigned SYNC_STAGES      = 2;
  // register map, byte addresses
  localparam int unsigned ADDR_W           = 4;
  localparam logic [3:0]  OFS_CTRL         = 4'h0;
  localparam logic [3:0]  OFS_STATUS       = 4'h4;
  localparam logic [3:0]  OFS_EVENT        = 4'h8;
  // control fields
  localparam int unsigned CTRL_TO_RESET    = 0;
  localparam logic        CTRL_RESET_VAL   = 1'b0;
  // status fields
  localparam int unsigned ST_UV_LSB        = 0;
  localparam int unsigned ST_RST_ACTIVE    = 8;
  localparam int unsigned ST_WDO_FLAG      = 9;
  localparam int unsigned ST_MARGIN_HOLD   = 10;
  localparam int unsigned ST_KICK_EN       = 11;
  // event fields, write one to clear
  localparam int unsigned EV_WD_EXPIRED    = 0;
  localparam int unsigned EV_RST_RELEASED  = 1;
  localparam int unsigned EV_W             = 2;
endpackage : msw_pkg

// file: design/msw_sync_if.sv
// carrier between the input synchroniser and the supervisor core
`timescale 1ns/1ns
interface msw_sync_if #(parameter int unsigned N = msw_pkg::RAILS);
  logic [N-1:0] uv5_raw;
  logic [N-1:0] uv10_raw;
  logic         tol_raw;
  logic         mr_raw_n;
  logic         margin_raw_n;
  logic         kick_raw;
  logic         kick_en_raw;
  logic [N-1:0] uv;
  logic         mr_n;
  logic         margin_n;
  logic         kick;
  logic         kick_en;
  modport sync (input uv5_raw, uv10_raw, tol_raw, mr_raw_n, margin_raw_n, kick_raw, kick_en_raw,
                output uv, mr_n, margin_n, kick, kick_en);
  modport core (output uv5_raw, uv10_raw, tol_raw, mr_raw_n, margin_raw_n, kick_raw, kick_en_raw,
                input uv, mr_n, margin_n, kick, kick_en);
endinterface : msw_sync_if

// file: design/msw_sync.sv
// two-stage synchroniser for rail flags and control pins
`timescale 1ns/1ns
module msw_sync #(
  parameter int unsigned N = msw_pkg::RAILS
) (
  input wire logic clk_i,         // system clock
  input wire logic rstn_i,        // async reset, active low
  msw_sync_if.sync sif            // raw in, synchronised out
);
  localparam int unsigned W = N + 4;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } msw_sync_state_type;

  msw_sync_state_type s_ff;
  msw_sync_state_type nxt_s;
  logic [N-1:0]       uv_sel;

  // tolerance picks which comparator set is watched
  always_comb begin
    uv_sel = sif.tol_raw ? sif.uv10_raw : sif.uv5_raw;
    nxt_s    = s_ff;
    nxt_s.s1 = {sif.kick_en_raw, sif.kick_raw, sif.margin_raw_n, sif.mr_raw_n, uv_sel};
    nxt_s.s2 = s_ff.s1;
  end

  // inactive levels at reset: rails good, pins released
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_ff <= '{s1: {4'h3, {N{1'b0}}}, s2: {4'h3, {N{1'b0}}}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // only the second stage leaves the module
  assign sif.uv       = s_ff.s2[N-1:0];
  assign sif.mr_n     = s_ff.s2[N];
  assign sif.margin_n = s_ff.s2[N+1];
  assign sif.kick     = s_ff.s2[N+2];
  assign sif.kick_en  = s_ff.s2[N+3];
endmodule : msw_sync

// file: verification/msw_sva.sv
// assertion checker on the supervisor top ports
`timescale 1ns/1ns
module msw_sva #(
  parameter int unsigned N        = 8,  // rails
  parameter int unsigned HOLD_CYC = 20, // hold count
  parameter int unsigned WD_CYC   = 50, // watchdog count
  parameter int unsigned MD_CYC   = 5   // margin delay
) (
  input wire logic         clk_i,                     // clock
  input wire logic         rstn_i,                    // reset
  input wire logic [N-1:0] rail_uv5_i,                // 5% flags
  input wire logic [N-1:0] rail_uv10_i,               // 10% flags
  input wire logic         threshold_tolerance_sel_i, // tolerance
  input wire logic         manual_reset_n_i,          // manual reset
  input wire logic         margin_n_i,                // margin
  input wire logic [N-1:0] rail_status_n_o,           // rail status
  input wire logic         sys_reset_n_o,             // reset out
  input wire logic         watchdog_fault_out_n_o     // fault out
);
  logic [N-1:0] uv;
  logic         ok;
  int           st_ff;
  int           gd_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // selected flags; ok once margin has been off long enough
  assign uv = threshold_tolerance_sel_i ? rail_uv10_i : rail_uv5_i;
  assign ok = st_ff > MD_CYC + 8;
  // cycles since margin off and since inputs all good
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= 0;
      gd_ff <= 0;
    end else begin
      st_ff <= margin_n_i ? st_ff + 1 : 0;
      gd_ff <= (uv == '0 && manual_reset_n_i) ? gd_ff + 1 : 0;
    end
  end
  sequence s_mr; (ok && !manual_reset_n_i)[*4]; endsequence
  property p_rail; (ok && $stable(uv))[*4] |-> rail_status_n_o == ~uv; endproperty
  a_rail: assert property (p_rail) else $error("rail status wrong");
  property p_rst_uv; (ok && |uv)[*4] |-> !sys_reset_n_o; endproperty
  a_rst_uv: assert property (p_rst_uv) else $error("reset high with rail low");
  property p_rst_mr; s_mr |-> !sys_reset_n_o; endproperty
  a_rst_mr: assert property (p_rst_mr) else $error("reset high with manual low");
  property p_hold; ok && $rose(sys_reset_n_o) |-> gd_ff >= HOLD_CYC; endproperty
  a_hold: assert property (p_hold) else $error("reset released early");
  property p_wdo_uv; (ok && |uv)[*4] |-> !watchdog_fault_out_n_o; endproperty
  a_wdo_uv: assert property (p_wdo_uv) else $error("fault high with rail low");
  property p_wdo_mr; s_mr and (uv == '0)[*4] |-> watchdog_fault_out_n_o; endproperty
  a_wdo_mr: assert property (p_wdo_mr) else $error("fault kept with manual low");
  property p_margin; (!margin_n_i)[*5] |-> &{rail_status_n_o, sys_reset_n_o, watchdog_fault_out_n_o}; endproperty
  a_margin: assert property (p_margin) else $error("output low in margin");
  property p_freeze; (!margin_n_i)[*6] |-> $stable({rail_status_n_o, sys_reset_n_o, watchdog_fault_out_n_o}); endproperty
  a_freeze: assert property (p_freeze) else $error("output moved in margin");
endmodule : msw_sva
bind msw_top msw_sva #(.N(N), .HOLD_CYC(HOLD_CYC), .WD_CYC(WD_CYC), .MD_CYC(MD_CYC)) msw_sva_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .rail_uv5_i(rail_uv5_i), .rail_uv10_i(rail_uv10_i),
  .threshold_tolerance_sel_i(threshold_tolerance_sel_i), .manual_reset_n_i(manual_reset_n_i),
  .margin_n_i(margin_n_i), .rail_status_n_o(rail_status_n_o), .sys_reset_n_o(sys_reset_n_o),
  .watchdog_fault_out_n_o(watchdog_fault_out_n_o));

// file: verification/msw_host.sv
// processor model: kicks the watchdog or leaves the pin floating
`timescale 1ns/1ns
module msw_host #(
  parameter int unsigned PER = 10 // kick interval
) (
  input  wire logic clk_i,   // clock
  input  wire logic rstn_i,  // reset
  input  wire logic drive_i, // drive the pin
  input  wire logic run_i,   // kick periodically
  output logic      kick_o,  // kick pin
  output logic      driven_o // pin driven
);
  int cnt_ff;
  assign driven_o = drive_i;
  // floating pin wanders each cycle; driven pin toggles once a period
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 0;
      kick_o <= 1'h0;
    end else if (!drive_i) begin
      kick_o <= ~kick_o;
    end else if (run_i) begin
      cnt_ff <= (cnt_ff == PER - 1) ? 0 : cnt_ff + 1;
      kick_o <= (cnt_ff == PER - 1) ? ~kick_o : kick_o;
    end
  end
endmodule : msw_host

// file: verification/tb_top.sv
// self-checking bench for the multi-rail supervisor
`timescale 1ns/1ns
module tb_top;
  localparam int HC = 20;
  localparam int WC = 50;
  localparam int MC = 5;
  localparam int PR = 10;
  logic        clk_i = 1'h0, rstn = 1'h0, threshold_tolerance_sel = 1'h0, mr = 1'h1, mg = 1'h1, drv = 1'h1, run = 1'h1;
  logic        rd = 1'h0, wr = 1'h0, kk, kd, rso, watchdog_fault_out_n, wq;
  logic [7:0]  u5 = 8'h0, u10 = 8'h0, st;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdo, rdat;
  int          failures = 0, checks_done = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  msw_host #(.PER(PR)) msw_host_inst (.clk_i(clk_i), .rstn_i(rstn), .drive_i(drv), .run_i(run),
    .kick_o(kk), .driven_o(kd));
  msw_top #(.N(8), .HOLD_CYC(HC), .WD_CYC(WC), .MD_CYC(MC)) msw_top_inst (.clk_i(clk_i), .rstn_i(rstn),
    .rail_uv5_i(u5), .rail_uv10_i(u10), .threshold_tolerance_sel_i(threshold_tolerance_sel), .manual_reset_n_i(mr),
    .margin_n_i(mg), .watchdog_kick_in_i(kk), .watchdog_kick_driven_i(kd), .rail_status_n_o(st),
    .sys_reset_n_o(rso), .watchdog_fault_out_n_o(watchdog_fault_out_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wq));
  // counted compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one access held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic r);
    int n;
    n = 0;
    @(posedge clk_i);
    adr  <= a;
    wdat <= d;
    rd   <= r;
    wr   <= ~r;
    // look at waitrequest mid-cycle, so the edge that follows is the one where it is sampled low
    do begin
      @(negedge clk_i);
      n++;
    end while (wq !== 1'h0 && n < 20);
    rdat = rdo;
    @(posedge clk_i);
    rd <= 1'h0;
    wr <= 1'h0;
    chk("waitrequest", 32'h0, 32'(wq));
  endtask : bus
  // wait for fault (w) or reset to reach v; lo above hi means it must not
  task automatic wt(input bit w, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while ((w ? watchdog_fault_out_n : rso) !== v && n <= hi) begin
      @(negedge clk_i);
      n++;
    end
    chk(w ? "fault_time" : "reset_time", 32'h1, 32'(n >= lo && n <= hi + (lo > hi)));
  endtask : wt
  // verdict
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // scenarios
  initial begin
    repeat (6) @(posedge clk_i);
    rstn <= 1'h1;
    wt(0, 1'h1, HC, HC + 6);
    bus(4'h0, 32'h0, 1'h1);
    chk("ctrl", 32'h0, rdat);
    bus(4'h8, 32'h0, 1'h1);
    chk("event", 32'h2, rdat);
    bus(4'h8, 32'h2, 1'h0);
    bus(4'hc, 32'h1, 1'h0);
    bus(4'hc, 32'h0, 1'h1);
    chk("unmapped", 32'h0, rdat);
    bus(4'h4, 32'hffff_ffff, 1'h0);
    bus(4'h4, 32'h0, 1'h1);
    chk("status", 32'h800, rdat);
    @(posedge clk_i);
    u5  <= 8'h5a;
    u10 <= 8'h81;
    wt(1, 1'h0, 2, 6);
    @(negedge clk_i);
    chk("status_5", 32'ha5, 32'(st));
    chk("reset_rail", 32'h0, 32'(rso));
    @(posedge clk_i);
    threshold_tolerance_sel <= 1'h1;
    repeat (5) @(negedge clk_i);
    chk("status_10", 32'h7e, 32'(st));
    @(posedge clk_i);
    u10 <= 8'h0;
    wt(1, 1'h1, 2, 6);
    chk("reset_held", 32'h0, 32'(rso));
    wt(0, 1'h1, HC - 2, HC + 2);
    wt(1, 1'h0, 3 * WC + 1, 3 * WC);
    @(posedge clk_i);
    run <= 1'h0;
    wt(1, 1'h0, WC - PR, WC + 6);
    bus(4'h8, 32'h0, 1'h1);
    chk("event_wd", 32'h3, rdat);
    @(posedge clk_i);
    run <= 1'h1;
    wt(1, 1'h1, 1, PR + 6);
    @(posedge clk_i);
    run <= 1'h0;
    wt(1, 1'h0, WC - PR, WC + 6);
    @(posedge clk_i);
    mr <= 1'h0;
    wt(1, 1'h1, 1, 6);
    wt(0, 1'h0, 0, 6);
    @(posedge clk_i);
    mr <= 1'h1;
    wt(1, 1'h0, HC + WC, HC + WC + 8);
    bus(4'h0, 32'h1, 1'h0);
    bus(4'h0, 32'h0, 1'h1);
    chk("ctrl_rw", 32'h1, rdat);
    @(posedge clk_i);
    mr <= 1'h0;
    repeat (4) @(posedge clk_i);
    mr <= 1'h1;
    wt(0, 1'h1, HC, HC + 8);
    wt(0, 1'h0, WC - 2, WC + 6);
    chk("fault_reset_mode", 32'h1, 32'(watchdog_fault_out_n));
    bus(4'h0, 32'h0, 1'h0);
    @(posedge clk_i);
    drv <= 1'h0;
    mr  <= 1'h0;
    repeat (4) @(posedge clk_i);
    mr <= 1'h1;
    wt(0, 1'h1, HC, HC + 8);
    wt(1, 1'h0, 2 * WC + 1, 2 * WC);
    bus(4'h4, 32'h0, 1'h1);
    chk("status_off", 32'h0, rdat);
    @(posedge clk_i);
    drv <= 1'h1;
    mg  <= 1'h0;
    wt(1, 1'h0, WC + 11, WC + 10);
    @(posedge clk_i);
    u10 <= 8'hff;
    repeat (6) @(negedge clk_i);
    chk("margin_out", 32'h3ff, 32'({st, rso, watchdog_fault_out_n}));
    @(posedge clk_i);
    u10 <= 8'h0;
    repeat (8) @(posedge clk_i);
    mg <= 1'h1;
    wt(1, 1'h0, MC + 1, MC + 8);
    finish_test();
  end
endmodule : tb_top
